// ===== fcsv_pkg.sv
// Overview of operation
// - Code 0x01 verifies every data and program block is erased, result in status.
// - Code 0x02 on the data block verifies that whole block is erased.
// - Code 0x08 erases all blocks; needs both disables, program open, data open set.
// - Code 0x09 erases one block; full data block erase needs data open set.
// - Code 0x0B erases all blocks then verifies all erased, releasing security if the verify reports no error.
// - Code 0x0D selects the user margin read level for data reads.
// - Code 0x0E selects the field margin level; accepted only in special modes.
// - Code 0x10 verifies a given count of words from a start address erased.
// - Code 0x11 programs one to four words; 0x12 erases one data sector.
// - Program or erase before divider setup sets access error, command dropped.
// - Unsupported command code sets access error and the command is dropped.
// - Reading a block while its algorithm runs returns invalid data.
// - Such a read sets both fault flags if clear and captures its address.
// - Erase-verify-all loads 0x01 at index 0, launch, completion set at end.
// - Erase-verify-all and erase-verify-block raise access error unless index is 0 at launch.
// - Verify sets any-error bit on errors, uncorrectable bit on uncorrectable ones.
// - Erase-verify-block address bits 22:16 must name a valid block.
// - Erase-verify-block checks the chosen block and sets completion when done.
package fcsv_pkg;
  localparam logic [7:0] OFS_CLKDIV = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_INDEX = 8'h08;
  localparam logic [7:0] OFS_PARAM = 8'h0c;
  localparam logic [7:0] OFS_PPROT = 8'h10;
  localparam logic [7:0] OFS_DPROT = 8'h14;
  localparam logic [7:0] OFS_FAULT = 8'h18;
  localparam logic [7:0] OFS_FADDR = 8'h1c;
  localparam logic [7:0] OFS_FDATA = 8'h20;
  localparam logic [7:0] OFS_MARGIN = 8'h24;
  localparam int unsigned ST_COMPLETE = 7;
  localparam int unsigned ST_ACCESS_ERROR_FLAG = 5;
  localparam int unsigned ST_PVIOL = 4;
  localparam int unsigned ST_VANY = 1;
  localparam int unsigned ST_VUNC = 0;
  localparam int unsigned DIV_W = 7;
  localparam int unsigned DIV_LOADED = 7;
  localparam int unsigned PP_OPEN = 7;
  localparam int unsigned PP_HDIS = 5;
  localparam int unsigned PP_LDIS = 2;
  localparam int unsigned DP_OPEN = 7;
  localparam int unsigned FLT_DOUBLE = 1;
  localparam int unsigned FLT_SINGLE = 0;
  localparam int unsigned MRG_FIELD = 4;
  localparam logic [7:0] PPROT_RST = 8'h00;
  localparam logic [7:0] DPROT_RST = 8'h00;
  localparam logic [7:0] CMD_VFY_ALL = 8'h01;
  localparam logic [7:0] CMD_VFY_BLK = 8'h02;
  localparam logic [7:0] CMD_ERS_ALL = 8'h08;
  localparam logic [7:0] CMD_ERS_BLK = 8'h09;
  localparam logic [7:0] CMD_UNSEC = 8'h0b;
  localparam logic [7:0] CMD_USR_MRG = 8'h0d;
  localparam logic [7:0] CMD_FLD_MRG = 8'h0e;
  localparam logic [7:0] CMD_VFY_DSEC = 8'h10;
  localparam logic [7:0] CMD_PRG_D = 8'h11;
  localparam logic [7:0] CMD_ERS_DSEC = 8'h12;
  localparam logic [2:0] IDX_0 = 3'h0;
  localparam logic [2:0] IDX_1 = 3'h1;
  localparam logic [2:0] IDX_2 = 3'h2;
  localparam logic [2:0] IDX_5 = 3'h5;
  localparam logic [6:0] DFLASH_BLK = 7'h10;
  localparam logic [6:0] PFLASH_BLK_LO = 7'h7e;
  localparam logic [6:0] PFLASH_BLK_HI = 7'h7f;
  localparam int unsigned CMD_LSB = 8;
  localparam int unsigned BLK_W = 7;
  localparam int unsigned MRG_W = 2;
  typedef enum logic [2:0] {
    OP_VERIFY_ALL, OP_VERIFY_BLOCK, OP_VERIFY_SECTION, OP_ERASE_ALL,
    OP_ERASE_BLOCK, OP_ERASE_SECTOR, OP_PROGRAM
  } fcsv_op_t;
  typedef struct packed {
    logic start;
    fcsv_op_t op;
    logic [6:0] blk;
    logic [15:0] addr;
    logic [15:0] count;
    logic [2:0] nwords;
    logic [3:0][15:0] data;
  } fcsv_arr_req_t;
  typedef struct packed {
    logic done;
    logic err_any;
    logic err_unc;
  } fcsv_arr_rsp_t;
  typedef struct packed {
    logic valid;
    logic [22:0] addr;
  } fcsv_rd_req_t;
endpackage : fcsv_pkg

// ===== fcsv_sequencer.sv
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fcsv_sequencer
  import fcsv_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned NUM_WORDS = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic special_mode_pin,
  input wire fcsv_rd_req_t cpu_rd,
  output logic cpu_rd_invalid,
  output fcsv_arr_req_t arr_req,
  input wire fcsv_arr_rsp_t arr_rsp,
  output logic [DIV_W-1:0] flash_clk_div,
  output logic [MRG_W-1:0] user_margin,
  output logic [MRG_W-1:0] field_margin,
  output logic security_released
);

  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_WAIT} fcsv_state_t;

  fcsv_state_t state_q;
  logic spec_meta_q;
  logic spec_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [DIV_W-1:0] div_q;
  logic div_set_q;
  logic [7:0] pprot_q;
  logic [7:0] dprot_q;
  logic [2:0] index_q;
  logic [15:0] param_q [NUM_WORDS];
  logic complete_q;
  logic access_error_flag_q;
  logic pviol_q;
  logic vany_q;
  logic vunc_q;
  logic single_q;
  logic double_q;
  logic [22:0] faddr_q;
  logic rd_inv_q;
  fcsv_arr_req_t req_q;
  logic busy_all_q;
  logic [BLK_W-1:0] busy_blk_q;
  logic unsec_ph_q;
  logic [MRG_W-1:0] umrg_q;
  logic [MRG_W-1:0] fmrg_q;
  logic released_q;

  logic acc_phase;
  logic wr_en;
  logic [7:0] ofs;
  logic hit;
  logic [31:0] rd_mux;
  logic launch_go;
  logic [7:0] cmd;
  logic [BLK_W-1:0] blk;
  logic blk_is_d;
  logic blk_valid;
  logic known;
  logic idx_ok;
  logic need_div;
  logic need_spec;
  logic need_blk;
  logic pv_chk;
  logic acc_chk;
  logic is_margin;
  logic all_op;
  fcsv_op_t op_sel;
  logic chk_end;
  logic unsec_mid;
  logic op_end;
  logic rd_hit;

  // Mode strap arrives from a pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spec_meta_q <= 1'b0;
      spec_q <= 1'b0;
    end else begin
      spec_meta_q <= special_mode_pin;
      spec_q <= spec_meta_q;
    end
  end

  assign acc_phase = psel & penable & pready_q;
  assign wr_en = acc_phase & pwrite;
  assign ofs = paddr[7:0];
  assign launch_go = wr_en && ofs == OFS_STATUS && pwdata[ST_COMPLETE] && complete_q
                     && !access_error_flag_q && !pviol_q && state_q == S_IDLE;

  always_comb begin
    hit = (paddr >> 8) == '0;
    rd_mux = 32'h0000_0000;
    unique case (ofs)
      OFS_CLKDIV: begin
        rd_mux[DIV_LOADED] = div_set_q;
        rd_mux[DIV_W-1:0] = div_q;
      end
      OFS_STATUS: begin
        rd_mux[ST_COMPLETE] = complete_q;
        rd_mux[ST_ACCESS_ERROR_FLAG] = access_error_flag_q;
        rd_mux[ST_PVIOL] = pviol_q;
        rd_mux[ST_VANY] = vany_q;
        rd_mux[ST_VUNC] = vunc_q;
      end
      OFS_INDEX: rd_mux[2:0] = index_q;
      OFS_PARAM: begin
        if (index_q < NUM_WORDS) begin
          rd_mux[15:0] = param_q[index_q];
        end
      end
      OFS_PPROT: rd_mux[7:0] = pprot_q;
      OFS_DPROT: rd_mux[7:0] = dprot_q;
      OFS_FAULT: begin
        rd_mux[FLT_DOUBLE] = double_q;
        rd_mux[FLT_SINGLE] = single_q;
      end
      // Captured data of an invalid read is always zero
      OFS_FADDR: rd_mux[22:0] = faddr_q;
      OFS_FDATA: rd_mux = 32'h0000_0000;
      OFS_MARGIN: begin
        rd_mux[MRG_FIELD +: MRG_W] = fmrg_q;
        rd_mux[MRG_W-1:0] = umrg_q;
      end
      default: hit = 1'b0;
    endcase
  end

  // No wait state: answer is prepared during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit;
      prdata_q <= (psel & ~penable & ~pwrite & hit) ? rd_mux : 32'h0000_0000;
    end
  end

  // Command word layout
  assign cmd = param_q[0][CMD_LSB +: 8];
  assign blk = param_q[0][BLK_W-1:0];
  assign blk_is_d = blk == DFLASH_BLK;
  assign blk_valid = blk_is_d || (blk >= PFLASH_BLK_LO && blk <= PFLASH_BLK_HI);

  always_comb begin
    known = 1'b1;
    idx_ok = index_q == IDX_0;
    need_div = 1'b0;
    need_spec = 1'b0;
    need_blk = 1'b0;
    pv_chk = 1'b0;
    is_margin = 1'b0;
    all_op = 1'b0;
    op_sel = OP_VERIFY_ALL;
    unique case (cmd)
      CMD_VFY_ALL: begin
        all_op = 1'b1;
      end
      CMD_VFY_BLK: begin
        need_blk = 1'b1;
        op_sel = OP_VERIFY_BLOCK;
      end
      CMD_ERS_ALL: begin
        need_div = 1'b1;
        need_spec = 1'b1;
        all_op = 1'b1;
        op_sel = OP_ERASE_ALL;
        pv_chk = !(pprot_q[PP_LDIS] && pprot_q[PP_HDIS] && pprot_q[PP_OPEN]
                   && dprot_q[DP_OPEN]);
      end
      CMD_ERS_BLK: begin
        need_div = 1'b1;
        need_blk = 1'b1;
        op_sel = OP_ERASE_BLOCK;
        pv_chk = blk_is_d ? !dprot_q[DP_OPEN]
               : !(pprot_q[PP_LDIS] && pprot_q[PP_HDIS] && pprot_q[PP_OPEN]);
      end
      CMD_UNSEC: begin
        need_div = 1'b1;
        need_spec = 1'b1;
        all_op = 1'b1;
        op_sel = OP_ERASE_ALL;
      end
      CMD_USR_MRG: begin
        idx_ok = index_q == IDX_1;
        is_margin = 1'b1;
      end
      CMD_FLD_MRG: begin
        idx_ok = index_q == IDX_1;
        need_spec = 1'b1;
        is_margin = 1'b1;
      end
      CMD_VFY_DSEC: begin
        idx_ok = index_q == IDX_2;
        op_sel = OP_VERIFY_SECTION;
      end
      CMD_PRG_D: begin
        idx_ok = index_q >= IDX_2 && index_q <= IDX_5;
        need_div = 1'b1;
        op_sel = OP_PROGRAM;
        pv_chk = !dprot_q[DP_OPEN];
      end
      CMD_ERS_DSEC: begin
        idx_ok = index_q == IDX_1;
        need_div = 1'b1;
        op_sel = OP_ERASE_SECTOR;
        pv_chk = !dprot_q[DP_OPEN];
      end
      default: known = 1'b0;
    endcase
  end

  assign acc_chk = !known || !idx_ok || (need_div && !div_set_q)
                   || (need_spec && !spec_q) || (need_blk && !blk_valid);
  assign chk_end = state_q == S_CHECK && (acc_chk || pv_chk || is_margin);
  assign unsec_mid = req_q.op == OP_ERASE_ALL && !unsec_ph_q && cmd == CMD_UNSEC;
  assign op_end = state_q == S_WAIT && arr_rsp.done && !unsec_mid;
  assign rd_hit = cpu_rd.valid && !complete_q && state_q == S_WAIT
                  && (busy_all_q || cpu_rd.addr[22:16] == busy_blk_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      req_q <= '0;
      busy_all_q <= 1'b0;
      busy_blk_q <= '0;
      unsec_ph_q <= 1'b0;
    end else begin
      req_q.start <= 1'b0;
      unique case (state_q)
        S_IDLE: begin
          if (launch_go) begin
            state_q <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (acc_chk || pv_chk || is_margin) begin
            state_q <= S_IDLE;
          end else begin
            state_q <= S_WAIT;
            req_q.start <= 1'b1;
            req_q.op <= op_sel;
            req_q.blk <= blk;
            req_q.addr <= param_q[1];
            req_q.count <= param_q[2];
            req_q.nwords <= index_q - IDX_1;
            for (int i = 0; i < 4; i++) begin
              req_q.data[i] <= param_q[i+2];
            end
            busy_all_q <= all_op;
            busy_blk_q <= blk;
            unsec_ph_q <= 1'b0;
          end
        end
        S_WAIT: begin
          if (unsec_mid && arr_rsp.done) begin
            req_q.start <= 1'b1;
            req_q.op <= OP_VERIFY_ALL;
            unsec_ph_q <= 1'b1;
          end else if (arr_rsp.done) begin
            state_q <= S_IDLE;
            busy_all_q <= 1'b0;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Status flags: hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      complete_q <= 1'b1;
      access_error_flag_q <= 1'b0;
      pviol_q <= 1'b0;
      vany_q <= 1'b0;
      vunc_q <= 1'b0;
      released_q <= 1'b0;
    end else begin
      if (launch_go) begin
        complete_q <= 1'b0;
        vany_q <= 1'b0;
        vunc_q <= 1'b0;
      end else if (chk_end || op_end) begin
        complete_q <= 1'b1;
      end
      if (state_q == S_CHECK && acc_chk) begin
        access_error_flag_q <= 1'b1;
      end else if (wr_en && ofs == OFS_STATUS && pwdata[ST_ACCESS_ERROR_FLAG]) begin
        access_error_flag_q <= 1'b0;
      end
      if (state_q == S_CHECK && !acc_chk && pv_chk) begin
        pviol_q <= 1'b1;
      end else if (wr_en && ofs == OFS_STATUS && pwdata[ST_PVIOL]) begin
        pviol_q <= 1'b0;
      end
      if (op_end) begin
        vany_q <= vany_q | arr_rsp.err_any;
        vunc_q <= vunc_q | arr_rsp.err_unc;
      end
      if (op_end && cmd == CMD_UNSEC && !arr_rsp.err_any) begin
        released_q <= 1'b1;
      end
    end
  end

  // Invalid read capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      single_q <= 1'b0;
      double_q <= 1'b0;
      faddr_q <= '0;
      rd_inv_q <= 1'b0;
    end else begin
      rd_inv_q <= rd_hit;
      if (rd_hit && !single_q && !double_q) begin
        single_q <= 1'b1;
        double_q <= 1'b1;
        faddr_q <= cpu_rd.addr;
      end else if (wr_en && ofs == OFS_FAULT) begin
        single_q <= single_q & ~pwdata[FLT_SINGLE];
        double_q <= double_q & ~pwdata[FLT_DOUBLE];
      end
    end
  end

  // Margin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      umrg_q <= '0;
      fmrg_q <= '0;
    end else if (state_q == S_CHECK && !acc_chk && is_margin) begin
      if (cmd == CMD_USR_MRG) begin
        umrg_q <= param_q[1][MRG_W-1:0];
      end else begin
        fmrg_q <= param_q[1][MRG_W-1:0];
      end
    end
  end

  // Configuration and command words; frozen while a command runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      div_set_q <= 1'b0;
      pprot_q <= PPROT_RST;
      dprot_q <= DPROT_RST;
      index_q <= IDX_0;
      for (int i = 0; i < NUM_WORDS; i++) begin
        param_q[i] <= 16'h0000;
      end
    end else if (wr_en && complete_q && state_q == S_IDLE) begin
      unique case (ofs)
        OFS_CLKDIV: begin
          div_q <= pwdata[DIV_W-1:0];
          div_set_q <= 1'b1;
        end
        OFS_PPROT: pprot_q <= pwdata[7:0];
        OFS_DPROT: dprot_q <= pwdata[7:0];
        OFS_INDEX: index_q <= pwdata[2:0];
        OFS_PARAM: begin
          if (index_q < NUM_WORDS) begin
            param_q[index_q] <= pwdata[15:0];
          end
        end
        default: ;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cpu_rd_invalid = rd_inv_q;
  assign arr_req = req_q;
  assign flash_clk_div = div_q;
  assign user_margin = umrg_q;
  assign field_margin = fmrg_q;
  assign security_released = released_q;

endmodule : fcsv_sequencer
`default_nettype wire

// ===== fcsv_properties.sv
`timescale 1ns/1ps
`default_nettype none
module fcsv_properties
  import fcsv_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned NUM_WORDS = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic special_mode_pin,
  input wire fcsv_rd_req_t cpu_rd,
  input wire logic cpu_rd_invalid,
  input wire fcsv_arr_req_t arr_req,
  input wire fcsv_arr_rsp_t arr_rsp,
  input wire logic [DIV_W-1:0] flash_clk_div,
  input wire logic [MRG_W-1:0] user_margin,
  input wire logic [MRG_W-1:0] field_margin,
  input wire logic security_released
);
  logic wr;
  logic launch;
  logic bad_addr;
  assign wr = psel && penable && pready && pwrite;
  assign launch = wr && paddr[7:0] == OFS_STATUS && pwdata[ST_COMPLETE];
  assign bad_addr = paddr[7:0] > OFS_MARGIN || paddr[1:0] != 2'h0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_start_cause;
    $past(launch, 2) || $past(launch, 3) || $past(arr_rsp.done) || $past(arr_rsp.done, 2);
  endsequence
  property p_ready_after_setup;
    s_setup |=> pready;
  endproperty
  property p_ready_single;
    pready |=> !pready;
  endproperty
  property p_err_map;
    pready |-> pslverr == bad_addr;
  endproperty
  property p_rdata_idle;
    !(pready && !pwrite) |-> prdata == 32'h0;
  endproperty
  property p_start_pulse;
    arr_req.start |=> !arr_req.start;
  endproperty
  property p_start_cause;
    arr_req.start |-> s_start_cause;
  endproperty
  property p_invalid_cause;
    cpu_rd_invalid |-> $past(cpu_rd.valid);
  endproperty
  property p_div_write;
    $changed(flash_clk_div) |-> $past(wr && paddr[7:0] == OFS_CLKDIV)
      && flash_clk_div == $past(pwdata[DIV_W-1:0]);
  endproperty
  property p_sec_sticky;
    security_released |=> security_released;
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
  a_ready_single: assert property (p_ready_single) else $error("ready longer than one cycle");
  a_err_map: assert property (p_err_map) else $error("slave error against address map");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero when idle");
  a_start_pulse: assert property (p_start_pulse) else $error("array start not a pulse");
  a_start_cause: assert property (p_start_cause) else $error("array start without launch");
  a_invalid_cause: assert property (p_invalid_cause) else $error("invalid flag without read");
  a_div_write: assert property (p_div_write) else $error("divider changed without write");
  a_sec_sticky: assert property (p_sec_sticky) else $error("security release dropped");
endmodule : fcsv_properties
bind fcsv_sequencer fcsv_properties #(.ADDR_W(ADDR_W), .NUM_WORDS(NUM_WORDS)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .special_mode_pin(special_mode_pin), .cpu_rd(cpu_rd), .cpu_rd_invalid(cpu_rd_invalid),
  .arr_req(arr_req), .arr_rsp(arr_rsp), .flash_clk_div(flash_clk_div),
  .user_margin(user_margin), .field_margin(field_margin),
  .security_released(security_released)
);
`default_nettype wire

// ===== fcsv_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fcsv_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, special_mode_pin;
  logic cpu_rd_invalid, security_released, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, w1;
  logic [31:0] seed = 32'hcf09;
  logic [1:0] le;
  fcsv_rd_req_t cpu_rd;
  fcsv_arr_req_t arr_req;
  fcsv_arr_rsp_t arr_rsp;
  logic [DIV_W-1:0] flash_clk_div;
  logic [MRG_W-1:0] user_margin, field_margin;
  int err_count = 0;
  int n_compared = 0;
  fcsv_sequencer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .special_mode_pin(special_mode_pin), .cpu_rd(cpu_rd),
    .cpu_rd_invalid(cpu_rd_invalid), .arr_req(arr_req), .arr_rsp(arr_rsp),
    .flash_clk_div(flash_clk_div), .user_margin(user_margin), .field_margin(field_margin),
    .security_released(security_released));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Flags byte plus the verify bits that the array reported
  function automatic logic [31:0] exp_st(logic [7:0] f, logic [1:0] e);
    return {24'h0, f | {6'h0, e}};
  endfunction : exp_st
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic bound(logic ok);
    if (ok !== 1'b1) begin
      err_count++;
      $display("[ERR] wait expected 1 seen 0");
      end_sim();
    end
  endtask : bound
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    bound(pready);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Loads the parameter words, launches, plays the array and checks the outcome
  task automatic cmd(logic [7:0] c, logic [6:0] b, logic [2:0] i, logic s, logic st,
      fcsv_op_t op, logic [7:0] f);
    logic [1:0] e;
    logic [22:0] ra;
    int n;
    logic [15:0] pw [6];
    w1 = rnd();
    ra = {b, w1[15:0]};
    w1 = rnd();
    // An uncorrectable error is an error as well
    e = (st && (op <= OP_VERIFY_SECTION || c == CMD_UNSEC)) ? {w1[1] | w1[0], w1[0]} : 2'h0;
    le = e;
    special_mode_pin <= s;
    apb(1'b1, OFS_INDEX, 32'h0);
    apb(1'b1, OFS_PARAM, {16'h0, c, 1'b0, b});
    for (int k = 1; k <= i; k++) begin
      w1 = rnd();
      pw[k] = w1[15:0];
      apb(1'b1, OFS_INDEX, k);
      apb(1'b1, OFS_PARAM, {16'h0, w1[15:0]});
    end
    apb(1'b1, OFS_STATUS, 32'h80);
    for (int j = 0; j < ((st && c == CMD_UNSEC) ? 2 : int'(st)); j++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (arr_req.start !== 1'b1 && n < 50);
      bound(arr_req.start);
      chk("op", (j == 1) ? OP_VERIFY_ALL : op, arr_req.op);
      if (j == 0) begin
        chk("blk", b, arr_req.blk);
        if (i >= IDX_1) begin
          chk("addr", pw[1], arr_req.addr);
        end
        if (i >= IDX_2) begin
          chk("count", pw[2], arr_req.count);
        end
        if (op == OP_PROGRAM) begin
          chk("nwords", i - IDX_1, arr_req.nwords);
          for (int k = 0; k < 4; k++) begin
            chk("data", pw[k+2], arr_req.data[k]);
          end
        end
        // Second read finds the fault flags set and must leave the captured address
        for (int r = 0; r < 2; r++) begin
          cpu_rd <= {1'b1, ra[22:1], ra[0] ^ r[0]};
          @(posedge pclk);
          cpu_rd <= '0;
          @(posedge pclk);
          chk("invalid", 32'h1, cpu_rd_invalid);
        end
      end
      arr_rsp <= {1'b1, (j == 1 || c != CMD_UNSEC) ? e : 2'h0};
      @(posedge pclk);
      arr_rsp <= '0;
    end
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[ST_COMPLETE] !== 1'b1 && n < 40);
    bound(rd[ST_COMPLETE]);
    chk("status", exp_st(f, e), rd);
    if (st) begin
      cpu_rd <= {1'b1, ra};
      @(posedge pclk);
      cpu_rd <= '0;
      @(posedge pclk);
      chk("valid read", 32'h0, cpu_rd_invalid);
      apb(1'b0, OFS_FAULT, 32'h0);
      chk("fault", 32'h3, rd);
      apb(1'b0, OFS_FADDR, 32'h0);
      chk("faddr", {9'h0, ra}, rd);
      apb(1'b1, OFS_FAULT, 32'h3);
    end
    apb(1'b1, OFS_STATUS, 32'h30);
  endtask : cmd
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    special_mode_pin = 1'b0;
    cpu_rd = '0;
    arr_rsp = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status reset", 32'h80, rd);
    apb(1'b0, OFS_PPROT, 32'h0);
    chk("pprot reset", {24'h0, PPROT_RST}, rd);
    apb(1'b0, OFS_DPROT, 32'h0);
    chk("dprot reset", {24'h0, DPROT_RST}, rd);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped read", 32'h1, se);
    apb(1'b1, 8'h2c, 32'hff);
    chk("unmapped write", 32'h1, se);
    cmd(CMD_ERS_BLK, DFLASH_BLK, IDX_0, 1'b1, 1'b0, OP_ERASE_BLOCK, 8'ha0);
    cmd(8'h05, DFLASH_BLK, IDX_0, 1'b1, 1'b0, OP_ERASE_BLOCK, 8'ha0);
    cmd(CMD_VFY_ALL, 7'h0, IDX_1, 1'b0, 1'b0, OP_VERIFY_ALL, 8'ha0);
    cmd(CMD_VFY_BLK, 7'h20, IDX_0, 1'b0, 1'b0, OP_VERIFY_BLOCK, 8'ha0);
    cmd(CMD_FLD_MRG, 7'h0, IDX_1, 1'b0, 1'b0, OP_PROGRAM, 8'ha0);
    w1 = rnd();
    apb(1'b1, OFS_CLKDIV, w1);
    apb(1'b0, OFS_CLKDIV, 32'h0);
    chk("divider", {24'h0, 1'b1, w1[6:0]}, rd);
    chk("divider out", {25'h0, w1[6:0]}, flash_clk_div);
    cmd(CMD_ERS_ALL, 7'h0, IDX_0, 1'b1, 1'b0, OP_ERASE_ALL, 8'h90);
    cmd(CMD_ERS_BLK, DFLASH_BLK, IDX_0, 1'b0, 1'b0, OP_ERASE_BLOCK, 8'h90);
    apb(1'b1, OFS_PPROT, 32'ha4);
    apb(1'b1, OFS_DPROT, 32'h80);
    cmd(CMD_VFY_ALL, 7'h0, IDX_0, 1'b0, 1'b1, OP_VERIFY_ALL, 8'h80);
    cmd(CMD_VFY_BLK, PFLASH_BLK_LO, IDX_0, 1'b0, 1'b1, OP_VERIFY_BLOCK, 8'h80);
    cmd(CMD_VFY_BLK, DFLASH_BLK, IDX_0, 1'b0, 1'b1, OP_VERIFY_BLOCK, 8'h80);
    cmd(CMD_ERS_ALL, 7'h0, IDX_0, 1'b1, 1'b1, OP_ERASE_ALL, 8'h80);
    cmd(CMD_ERS_BLK, DFLASH_BLK, IDX_0, 1'b0, 1'b1, OP_ERASE_BLOCK, 8'h80);
    cmd(CMD_UNSEC, 7'h0, IDX_0, 1'b1, 1'b1, OP_ERASE_ALL, 8'h80);
    chk("secure", {31'h0, le == 2'h0}, security_released);
    cmd(CMD_USR_MRG, 7'h0, IDX_1, 1'b0, 1'b0, OP_PROGRAM, 8'h80);
    chk("user margin", {30'h0, w1[1:0]}, user_margin);
    cmd(CMD_FLD_MRG, 7'h0, IDX_1, 1'b1, 1'b0, OP_PROGRAM, 8'h80);
    chk("field margin", {30'h0, w1[1:0]}, field_margin);
    cmd(CMD_VFY_DSEC, DFLASH_BLK, IDX_2, 1'b0, 1'b1, OP_VERIFY_SECTION, 8'h80);
    cmd(CMD_PRG_D, DFLASH_BLK, IDX_5, 1'b0, 1'b1, OP_PROGRAM, 8'h80);
    cmd(CMD_ERS_DSEC, DFLASH_BLK, IDX_1, 1'b0, 1'b1, OP_ERASE_SECTOR, 8'h80);
    end_sim();
  end
endmodule : tb
`default_nettype wire
